// ==== src/grant_link_pkg.sv ====
/*
 constants shared by both ends of the terminal to security module message link:
 message type bytes, field positions, limits, error codes and the terminal register map.
 assumes one clock for both ends and a byte wide link between them.
*/
package grant_link_pkg;
    // message type byte, first byte of every message
    localparam logic [7:0] MSG_HC_IND = 8'h01;
    localparam logic [7:0] MSG_BA_IND = 8'h02;
    localparam logic [7:0] MSG_HC_RESP = 8'h81;
    localparam logic [7:0] MSG_BA_RESP = 8'h82;
    localparam logic [7:0] MSG_BA_FAIL = 8'h83;
    localparam logic [7:0] HC_TMF_FILL = 8'h00;
    // assignment indication layout, payload byte positions
    localparam logic [7:0] IDX_FRAME = 8'h00;
    localparam logic [7:0] IDX_COUNT = 8'h01;
    localparam logic [7:0] BA_HDR_BYTES = 8'h03;
    localparam logic [11:0] BA_FIXED_BYTES = 12'h007;
    localparam logic [3:0] GRANT_LAST_BYTE = 4'h8;
    localparam logic [3:0] HDR_LAST_BYTE = 4'h3;
    localparam logic [3:0] TOD_LAST_BYTE = 4'h3;
    localparam logic [3:0] HC_LAST_BYTE = 4'h3;
    localparam int MAX_GRANTS = 5;
    localparam int SAT_GRANTS = 9;
    localparam int GRANT_BYTES = 9;
    localparam logic [7:0] MAX_COUNT = 8'h05;
    localparam logic [3:0] SAT_MAX = 4'h9;
    localparam logic [3:0] HC_RESP_LEN = 4'h7;
    localparam logic [3:0] BA_RESP_LEN = 4'h1;
    localparam logic [3:0] FAIL_HDR_LEN = 4'h2;
    // return and error codes
    localparam logic [7:0] RETURN_OK = 8'h00;
    localparam logic [7:0] RUNTIME_ABSENT = 8'h00;
    localparam logic [7:0] GEN_OK = 8'h00;
    localparam logic [7:0] GEN_BAD_COUNT = 8'h01;
    localparam logic [7:0] GEN_BAD_LENGTH = 8'h02;
    localparam logic [7:0] GEN_GRANT_ERR = 8'h03;
    localparam logic [7:0] GRANT_OK = 8'h00;
    localparam logic [7:0] GRANT_REJECT = 8'h01;
    localparam logic [7:0] GRANT_SHORT = 8'h02;
    // terminal register map, word per offset
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OWN_ID = 8'h01;
    localparam logic [7:0] REG_FRAME = 8'h02;
    localparam logic [7:0] REG_IF_VER = 8'h03;
    localparam logic [7:0] REG_SAT_COUNT = 8'h04;
    localparam logic [7:0] REG_TOD = 8'h05;
    localparam logic [7:0] REG_STATUS = 8'h06;
    localparam logic [7:0] REG_IRQ_EN = 8'h07;
    localparam logic [7:0] REG_IRQ_CLR = 8'h08;
    localparam logic [7:0] REG_RESP_LEN = 8'h09;
    localparam logic [7:0] REG_RESP_BASE = 8'h10;
    localparam logic [7:0] REG_GRANT_BASE = 8'h40;
    localparam int RESP_BYTES = 8;
    localparam int CTRL_SEND_HC = 0;
    localparam int CTRL_SEND_BA = 1;
    localparam int ST_HC = 0;
    localparam int ST_BA_OK = 1;
    localparam int ST_BA_FAIL = 2;
    localparam int ST_BUSY = 8;
    localparam int GRANT_ID_BYTE = 0;
endpackage

// ==== src/grant_link_if.sv ====
/*
 byte link between terminal end and security module end.
 assumes both ends run on the same clock; no back-pressure either way.
*/
`timescale 1ns/1ps
interface grant_link_if;
    logic h2d_valid;
    logic [7:0] h2d_data;
    logic h2d_last;
    logic d2h_valid;
    logic [7:0] d2h_data;
    logic d2h_last;
    modport terminal (output h2d_valid, output h2d_data, output h2d_last,
        input d2h_valid, input d2h_data, input d2h_last);
    modport module_end (input h2d_valid, input h2d_data, input h2d_last,
        output d2h_valid, output d2h_data, output d2h_last);
endinterface

// ==== src/security_module_end.sv ====
/*
 security module end: answers health checks, stores bandwidth grants, reports null
 success or failure codes. assumes the terminal end on the same clock and well formed
 message framing (type byte first, last marks final byte).
*/
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module security_module_end (
    input wire logic clk,
    input wire logic rst,
    grant_link_if.module_end link,
    input wire logic [7:0] boot_version,
    input wire logic [7:0] boot_if_rev,
    input wire logic runtime_present,
    input wire logic [7:0] runtime_version,
    input wire logic [7:0] cc_if_rev,
    input wire logic enrolled,
    input wire logic key_valid,
    input wire logic [4:0] grant_reject,
    input wire logic [2:0] grant_rd_slot,
    input wire logic [3:0] grant_rd_byte,
    output logic [7:0] grant_rd_data,
    output logic [7:0] stored_frame,
    output logic [7:0] stored_count,
    output logic grants_stored,
    output logic resp_dropped
);
    localparam int MAX_GRANTS = grant_link_pkg::MAX_GRANTS;
    localparam int GRANT_BYTES = grant_link_pkg::GRANT_BYTES;
    logic rx_first_r;
    logic [7:0] rx_type_r;
    logic [7:0] rx_idx_r;
    logic [7:0] rx_cnt_r;
    logic [7:0] rx_frame_r;
    logic [2:0] gslot_r;
    logic [3:0] gbyte_r;
    logic [7:0] grant_mem [0:MAX_GRANTS*GRANT_BYTES-1];
    logic [7:0] tx_buf [0:grant_link_pkg::RESP_BYTES-1];
    logic [7:0] resp_byte [0:grant_link_pkg::RESP_BYTES-1];
    logic [3:0] tx_len_r;
    logic [3:0] tx_idx_r;
    logic tx_busy_r;
    logic [7:0] grant_rd_data_r;
    logic [7:0] stored_frame_r;
    logic [7:0] stored_count_r;
    logic grants_stored_r;
    logic resp_dropped_r;
    logic d2h_valid_r;
    logic [7:0] d2h_data_r;
    logic d2h_last_r;
    logic [7:0] gcode [0:MAX_GRANTS-1];
    logic [4:0] gerr;

    // payload decode; the type byte itself is not payload
    wire pay = link.h2d_valid && !rx_first_r;
    wire done = link.h2d_valid && link.h2d_last;
    wire [7:0] done_type = rx_first_r ? link.h2d_data : rx_type_r;
    wire is_hc = done_type == grant_link_pkg::MSG_HC_IND;
    wire is_ba = done_type == grant_link_pkg::MSG_BA_IND;
    wire [7:0] cnt_now = (pay && rx_idx_r == grant_link_pkg::IDX_COUNT) ?
        link.h2d_data : rx_cnt_r;
    wire [7:0] frame_now = (pay && rx_idx_r == grant_link_pkg::IDX_FRAME) ?
        link.h2d_data : rx_frame_r;
    wire grant_wr = pay && rx_type_r == grant_link_pkg::MSG_BA_IND
        && rx_idx_r >= grant_link_pkg::BA_HDR_BYTES
        && {5'h00, gslot_r} < cnt_now && {5'h00, gslot_r} < grant_link_pkg::MAX_COUNT;
    wire slot_end = grant_wr && gbyte_r == grant_link_pkg::GRANT_LAST_BYTE;
    wire [2:0] full_now = slot_end ? gslot_r + 3'h1 : gslot_r;
    wire [5:0] wr_addr = 6'({gslot_r, 3'h0} + gslot_r + 6'(gbyte_r));
    wire [5:0] rd_addr = 6'({grant_rd_slot, 3'h0} + grant_rd_slot + 6'(grant_rd_byte));

    // length check: frame, count, version, nine bytes per grant, four check bytes
    wire [11:0] len_now = rx_first_r ? 12'h000 : 12'(rx_idx_r) + 12'h001;
    wire [11:0] exp_len = 12'({cnt_now, 3'h0}) + 12'(cnt_now) + grant_link_pkg::BA_FIXED_BYTES;
    wire count_bad = cnt_now > grant_link_pkg::MAX_COUNT;
    wire len_bad = len_now != exp_len;
    wire [7:0] gen_code = count_bad ? grant_link_pkg::GEN_BAD_COUNT :
        len_bad ? grant_link_pkg::GEN_BAD_LENGTH :
        (|gerr) ? grant_link_pkg::GEN_GRANT_ERR : grant_link_pkg::GEN_OK;
    wire ba_ok = gen_code == grant_link_pkg::GEN_OK;
    wire [3:0] fail_len = count_bad ? grant_link_pkg::FAIL_HDR_LEN :
        grant_link_pkg::FAIL_HDR_LEN + cnt_now[3:0];
    wire load = done && !tx_busy_r && (is_hc || is_ba);
    wire [3:0] resp_len = is_hc ? grant_link_pkg::HC_RESP_LEN :
        ba_ok ? grant_link_pkg::BA_RESP_LEN : fail_len;
    wire [7:0] runtime_field = runtime_present ? runtime_version :
        grant_link_pkg::RUNTIME_ABSENT;
    wire [7:0] flags = {6'h00, enrolled, key_valid};

    // per grant codes: missing bytes beat an outside rejection; zero is success
    generate
        for (genvar i = 0; i < MAX_GRANTS; i++)
        begin : g_code
            assign gcode[i] = (3'(i) >= full_now) ? grant_link_pkg::GRANT_SHORT :
                grant_reject[i] ? grant_link_pkg::GRANT_REJECT : grant_link_pkg::GRANT_OK;
            assign gerr[i] = (8'(i) < cnt_now) && (gcode[i] != grant_link_pkg::GRANT_OK);
        end
    endgenerate

    // response image; unused tail bytes are never sent
    always_comb
    begin
        for (int k = 0; k < grant_link_pkg::RESP_BYTES; k++)
            resp_byte[k] = 8'h00;
        if (is_hc)
        begin
            resp_byte[0] = grant_link_pkg::MSG_HC_RESP;
            resp_byte[1] = grant_link_pkg::RETURN_OK;
            resp_byte[2] = boot_version;
            resp_byte[3] = boot_if_rev;
            resp_byte[4] = runtime_field;
            resp_byte[5] = cc_if_rev;
            resp_byte[6] = flags;
        end
        else if (ba_ok)
            resp_byte[0] = grant_link_pkg::MSG_BA_RESP;
        else
        begin
            resp_byte[0] = grant_link_pkg::MSG_BA_FAIL;
            resp_byte[1] = gen_code;
            for (int k = 0; k < MAX_GRANTS; k++)
                resp_byte[k+2] = gcode[k];
        end
    end

    // receive framing and grant storage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_first_r <= 1'b1;
            rx_type_r <= 8'h00;
            rx_idx_r <= 8'h00;
            rx_cnt_r <= 8'h00;
            rx_frame_r <= 8'h00;
            gslot_r <= 3'h0;
            gbyte_r <= 4'h0;
        end
        else if (link.h2d_valid)
        begin
            rx_first_r <= link.h2d_last;
            rx_cnt_r <= link.h2d_last ? 8'h00 : cnt_now;
            rx_frame_r <= frame_now;
            if (rx_first_r)
            begin
                rx_type_r <= link.h2d_data;
                rx_idx_r <= 8'h00;
                gslot_r <= 3'h0;
                gbyte_r <= 4'h0;
            end
            else
            begin
                // saturate so an overlong message still fails the length check
                rx_idx_r <= (&rx_idx_r) ? rx_idx_r : rx_idx_r + 8'h01;
                gslot_r <= link.h2d_last ? 3'h0 : full_now;
                gbyte_r <= (slot_end || link.h2d_last) ? 4'h0 :
                    grant_wr ? gbyte_r + 4'h1 : gbyte_r;
            end
        end
    end

    // grant store and read port
    always_ff @(posedge clk)
    begin
        if (grant_wr)
            grant_mem[wr_addr] <= link.h2d_data;
        grant_rd_data_r <= (grant_rd_slot < 3'(MAX_GRANTS)) ? grant_mem[rd_addr] : 8'h00;
    end

    // outcome reporting; a message finishing while a response is still going out gets no answer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stored_frame_r <= 8'h00;
            stored_count_r <= 8'h00;
            grants_stored_r <= 1'b0;
            resp_dropped_r <= 1'b0;
        end
        else
        begin
            grants_stored_r <= done && is_ba && ba_ok;
            resp_dropped_r <= done && tx_busy_r && (is_hc || is_ba);
            if (done && is_ba && ba_ok)
            begin
                stored_frame_r <= frame_now;
                stored_count_r <= cnt_now;
            end
        end
    end

    // transmit: one byte per cycle, last flag on the final one
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_busy_r <= 1'b0;
            tx_len_r <= 4'h0;
            tx_idx_r <= 4'h0;
            d2h_valid_r <= 1'b0;
            d2h_data_r <= 8'h00;
            d2h_last_r <= 1'b0;
        end
        else if (tx_busy_r)
        begin
            d2h_valid_r <= 1'b1;
            d2h_data_r <= tx_buf[tx_idx_r[2:0]];
            d2h_last_r <= tx_idx_r == tx_len_r - 4'h1;
            tx_idx_r <= tx_idx_r + 4'h1;
            tx_busy_r <= tx_idx_r != tx_len_r - 4'h1;
        end
        else
        begin
            d2h_valid_r <= 1'b0;
            d2h_last_r <= 1'b0;
            if (load)
            begin
                tx_busy_r <= 1'b1;
                tx_len_r <= resp_len;
                tx_idx_r <= 4'h0;
            end
        end
    end

    // response image captured at the end of the message
    always_ff @(posedge clk)
    begin
        if (load)
            tx_buf <= resp_byte;
    end

    assign link.d2h_valid = d2h_valid_r;
    assign link.d2h_data = d2h_data_r;
    assign link.d2h_last = d2h_last_r;
    assign grant_rd_data = grant_rd_data_r;
    assign stored_frame = stored_frame_r;
    assign stored_count = stored_count_r;
    assign grants_stored = grants_stored_r;
    assign resp_dropped = resp_dropped_r;
endmodule // security_module_end

// ==== src/user_terminal_end.sv ====
/*
 user terminal end: software loads satellite grants and header values through a
 register port, orders a health check or an assignment forward, and sees responses.
 assumes the module end on the same clock.
*/
`timescale 1ns/1ps
module user_terminal_end (
    input wire logic clk,
    input wire logic rst,
    grant_link_if.terminal link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);
    typedef enum logic [2:0] {S_IDLE, S_HC, S_HDR, S_GRANT, S_TOD} tx_state_t;
    tx_state_t state_r;
    logic [7:0] own_id_r, frame_r, if_ver_r;
    logic [3:0] sat_count_r;
    logic [31:0] tod_r;
    logic [2:0] status_r, irq_en_r;
    logic [7:0] sat_mem [0:grant_link_pkg::SAT_GRANTS*grant_link_pkg::GRANT_BYTES-1];
    logic [7:0] resp_mem [0:grant_link_pkg::RESP_BYTES-1];
    logic [3:0] resp_len_r, rx_idx_r, b_r, g_r;
    logic [2:0] sent_r;
    logic [31:0] rdata_r;
    logic irq_r, valid_r, last_r;
    logic [7:0] data_r;
    logic [8:0] match;
    logic [3:0] fwd_cnt;

    wire [6:0] g_base = 7'({g_r, 3'h0} + g_r);
    wire [7:0] gidx = addr - grant_link_pkg::REG_GRANT_BASE;
    wire grant_sel = addr >= grant_link_pkg::REG_GRANT_BASE && gidx < 8'(grant_link_pkg::SAT_GRANTS*grant_link_pkg::GRANT_BYTES);
    wire [7:0] ridx = addr - grant_link_pkg::REG_RESP_BASE;
    wire resp_sel = addr >= grant_link_pkg::REG_RESP_BASE && ridx < 8'(grant_link_pkg::RESP_BYTES);
    wire idle = state_r == S_IDLE;
    wire ctrl_wr = wr && addr == grant_link_pkg::REG_CTRL && idle;
    wire clr_wr = wr && addr == grant_link_pkg::REG_IRQ_CLR;
    wire rx_end = link.d2h_valid && link.d2h_last;
    wire [7:0] rx_type = (rx_idx_r == 4'h0) ? link.d2h_data : resp_mem[0];
    wire grant_done = g_r >= sat_count_r || 4'(sent_r) >= fwd_cnt;

    // addressee filter over the loaded satellite grants
    generate
        for (genvar i = 0; i < grant_link_pkg::SAT_GRANTS; i++)
        begin : g_match
            assign match[i] = 4'(i) < sat_count_r
                && sat_mem[i*grant_link_pkg::GRANT_BYTES+grant_link_pkg::GRANT_ID_BYTE] == own_id_r;
        end
    endgenerate

    // forwarded count capped at five so the module never sees more
    always_comb
    begin
        fwd_cnt = 4'h0;
        for (int k = 0; k < grant_link_pkg::SAT_GRANTS; k++)
            if (match[k] && fwd_cnt < grant_link_pkg::MAX_COUNT[3:0])
                fwd_cnt = fwd_cnt + 4'h1;
    end

    // software registers; interrupt set wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            own_id_r <= 8'h00;
            frame_r <= 8'h00;
            if_ver_r <= 8'h00;
            sat_count_r <= 4'h0;
            tod_r <= 32'h00000000;
            irq_en_r <= 3'h0;
            status_r <= 3'h0;
            irq_r <= 1'b0;
        end
        else
        begin
            if (wr && addr == grant_link_pkg::REG_OWN_ID) own_id_r <= wdata[7:0];
            if (wr && addr == grant_link_pkg::REG_FRAME) frame_r <= wdata[7:0];
            if (wr && addr == grant_link_pkg::REG_IF_VER) if_ver_r <= wdata[7:0];
            if (wr && addr == grant_link_pkg::REG_SAT_COUNT)
                sat_count_r <= (wdata[3:0] > grant_link_pkg::SAT_MAX) ?
                    grant_link_pkg::SAT_MAX : wdata[3:0];
            if (wr && addr == grant_link_pkg::REG_TOD) tod_r <= wdata;
            if (wr && addr == grant_link_pkg::REG_IRQ_EN) irq_en_r <= wdata[2:0];
            status_r <= (status_r & ~(clr_wr ? wdata[2:0] : 3'h0)) | ({3{rx_end}} & {
                rx_type == grant_link_pkg::MSG_BA_FAIL,
                rx_type == grant_link_pkg::MSG_BA_RESP,
                rx_type == grant_link_pkg::MSG_HC_RESP});
            irq_r <= |(status_r & irq_en_r);
        end
    end

    // grant loading and read-back; read data stand one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (wr && grant_sel)
            sat_mem[gidx[6:0]] <= wdata[7:0];
        if (rst)
            rdata_r <= 32'h00000000;
        else if (rd)
            rdata_r <= grant_sel ? {24'h000000, sat_mem[gidx[6:0]]} :
                resp_sel ? {24'h000000, resp_mem[ridx[2:0]]} :
                addr == grant_link_pkg::REG_STATUS ? 32'({!idle, 5'h00, status_r}) :
                addr == grant_link_pkg::REG_IRQ_EN ? {29'h0, irq_en_r} :
                addr == grant_link_pkg::REG_RESP_LEN ? {28'h0, resp_len_r} :
                addr == grant_link_pkg::REG_OWN_ID ? {24'h000000, own_id_r} :
                addr == grant_link_pkg::REG_SAT_COUNT ? {28'h0, sat_count_r} : 32'h00000000;
    end

    // response capture, accepted at any time without stalling the sender
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_idx_r <= 4'h0;
            resp_len_r <= 4'h0;
        end
        else if (link.d2h_valid)
        begin
            if (rx_idx_r < 4'(grant_link_pkg::RESP_BYTES))
                resp_mem[rx_idx_r[2:0]] <= link.d2h_data;
            rx_idx_r <= rx_end ? 4'h0 : rx_idx_r + 4'h1;
            if (rx_end)
                resp_len_r <= rx_idx_r + 4'h1;
        end
    end

    // message sender: header, own grants only, then the copied check bytes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= S_IDLE;
            b_r <= 4'h0;
            g_r <= 4'h0;
            sent_r <= 3'h0;
            valid_r <= 1'b0;
            data_r <= 8'h00;
            last_r <= 1'b0;
        end
        else
        begin
            valid_r <= 1'b0;
            last_r <= 1'b0;
            unique case (state_r)
                S_IDLE:
                begin
                    b_r <= 4'h0;
                    g_r <= 4'h0;
                    sent_r <= 3'h0;
                    if (ctrl_wr && wdata[grant_link_pkg::CTRL_SEND_HC]) state_r <= S_HC;
                    else if (ctrl_wr && wdata[grant_link_pkg::CTRL_SEND_BA]) state_r <= S_HDR;
                end
                S_HC:
                begin
                    valid_r <= 1'b1;
                    data_r <= (b_r == 4'h0) ? grant_link_pkg::MSG_HC_IND : grant_link_pkg::HC_TMF_FILL;
                    last_r <= b_r == grant_link_pkg::HC_LAST_BYTE;
                    b_r <= b_r + 4'h1;
                    if (b_r == grant_link_pkg::HC_LAST_BYTE) state_r <= S_IDLE;
                end
                S_HDR:
                begin
                    valid_r <= 1'b1;
                    data_r <= (b_r == 4'h0) ? grant_link_pkg::MSG_BA_IND :
                        (b_r == 4'h1) ? frame_r : (b_r == 4'h2) ? {4'h0, fwd_cnt} : if_ver_r;
                    b_r <= (b_r == grant_link_pkg::HDR_LAST_BYTE) ? 4'h0 : b_r + 4'h1;
                    if (b_r == grant_link_pkg::HDR_LAST_BYTE) state_r <= S_GRANT;
                end
                S_GRANT:
                begin
                    if (grant_done)
                        state_r <= S_TOD;
                    else if (!match[g_r])
                        g_r <= g_r + 4'h1;
                    else
                    begin
                        valid_r <= 1'b1;
                        data_r <= sat_mem[g_base + 7'(b_r)];
                        b_r <= (b_r == grant_link_pkg::GRANT_LAST_BYTE) ? 4'h0 : b_r + 4'h1;
                        if (b_r == grant_link_pkg::GRANT_LAST_BYTE)
                        begin
                            g_r <= g_r + 4'h1;
                            sent_r <= sent_r + 3'h1;
                        end
                    end
                end
                S_TOD:
                begin
                    valid_r <= 1'b1;
                    data_r <= tod_r[31 - 8*b_r[1:0] -: 8];
                    last_r <= b_r == grant_link_pkg::TOD_LAST_BYTE;
                    b_r <= b_r + 4'h1;
                    if (b_r == grant_link_pkg::TOD_LAST_BYTE) state_r <= S_IDLE;
                end
            endcase
        end
    end

    assign link.h2d_valid = valid_r;
    assign link.h2d_data = data_r;
    assign link.h2d_last = last_r;
    assign rdata = rdata_r;
    assign irq = irq_r;
endmodule // user_terminal_end

// ==== bench/grant_link_chk.sv ====
/* link checker: watches the byte link between terminal end and module end.
   assumes one clock, synchronous active high reset, link sampled at posedge. */
`timescale 1ns/1ps
module grant_link_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic h2d_valid,
    input wire logic [7:0] h2d_data,
    input wire logic h2d_last,
    input wire logic d2h_valid,
    input wire logic [7:0] d2h_data,
    input wire logic d2h_last
);
    logic hsof_r;
    logic dsof_r;
    logic [5:0] idx_r;
    logic [7:0] typ_r;
    // framing trackers; 6 bits of index cover the longest assignment
    always_ff @(posedge clk) hsof_r <= rst | (h2d_valid ? h2d_last : hsof_r);
    always_ff @(posedge clk) dsof_r <= rst | (d2h_valid ? d2h_last : dsof_r);
    always_ff @(posedge clk) idx_r <= (rst | h2d_last) ? 6'h00 : idx_r + {5'h00, h2d_valid};
    always_ff @(posedge clk) typ_r <= (h2d_valid & hsof_r) ? h2d_data : typ_r;
    // an answer is only owed while the module end is idle, else it is dropped
    wire d_first = d2h_valid & dsof_r;
    wire hc_first = d_first & (d2h_data == 8'h81);
    wire ind_end = h2d_valid & h2d_last & dsof_r & ~d2h_valid;
    wire hc_end = ind_end & (typ_r == grant_link_pkg::MSG_HC_IND);
    wire ba_end = ind_end & (typ_r == grant_link_pkg::MSG_BA_IND);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_hc_tail; d2h_valid [*5] ##1 (d2h_valid & d2h_last); endsequence
    property p_hc_answer; hc_end |-> ##2 hc_first; endproperty
    a_hc_answer: assert property (p_hc_answer) else $error("no health answer");
    property p_hc_len; hc_first |=> s_hc_tail; endproperty
    a_hc_len: assert property (p_hc_len) else $error("health answer length");
    property p_hc_flags; hc_first |-> ##6 (d2h_data[7:2] == 6'h00); endproperty
    a_hc_flags: assert property (p_hc_flags) else $error("flag byte");
    property p_null; d_first & (d2h_data == 8'h82) |-> d2h_last; endproperty
    a_null: assert property (p_null) else $error("null answer not single");
    property p_fail; d_first & (d2h_data == 8'h83) |=> d2h_valid; endproperty
    a_fail: assert property (p_fail) else $error("failure without code");
    property p_ba_answer; ba_end |-> ##2 d_first & (d2h_data[7:1] == 7'h41); endproperty
    a_ba_answer: assert property (p_ba_answer) else $error("no assignment answer");
    property p_count; h2d_valid & (idx_r == 6'h02) & (typ_r == 8'h02) |-> h2d_data <= 8'h05;
    endproperty
    a_count: assert property (p_count) else $error("grant count too big");
    property p_ind_len; h2d_valid & hsof_r & (h2d_data == 8'h01) |-> ##3 h2d_last; endproperty
    a_ind_len: assert property (p_ind_len) else $error("health request length");
endmodule // grant_link_chk

// ==== bench/tb_bandwidth_grant_message_handler.sv ====
/* self-checking bench: both ends joined by the link, driven from the terminal
   register port. assumes the package, the link interface and the checker. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_bandwidth_grant_message_handler;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rp = 1'b0;
    logic en = 1'b0;
    logic kv = 1'b0;
    logic [4:0] rej = 5'h00;
    logic [2:0] slot = 3'h1;
    logic [31:0] rdata;
    logic irq;
    logic [7:0] frame;
    logic [7:0] count;
    logic [7:0] gdat;
    logic [31:0] v;
    logic stored;
    logic dropped;
    logic [7:0] tail;
    int n_stored = 0;
    int n_drop = 0;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    grant_link_if link ();
    user_terminal_end i_user_terminal_end (.clk(clk), .rst(rst), .link(link.terminal),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    security_module_end i_security_module_end (.clk(clk), .rst(rst), .link(link.module_end),
        .boot_version(8'hA1), .boot_if_rev(8'hB2), .runtime_present(rp), .enrolled(en),
        .runtime_version(8'hC3), .cc_if_rev(8'hD4), .key_valid(kv), .grant_reject(rej),
        .grant_rd_slot(slot), .grant_rd_byte(4'h1), .grant_rd_data(gdat), .stored_frame(frame),
        .stored_count(count), .grants_stored(stored), .resp_dropped(dropped));
    grant_link_chk i_grant_link_chk (.clk(clk), .rst(rst), .h2d_valid(link.h2d_valid),
        .h2d_data(link.h2d_data), .h2d_last(link.h2d_last), .d2h_valid(link.d2h_valid),
        .d2h_data(link.d2h_data), .d2h_last(link.d2h_last));
    initial forever #4 clk = ~clk;
    // last byte on the link, judged after the first assignment, and module outcome pulses, judged at the end of the run
    always @(posedge clk)
    begin
        if (link.h2d_valid && link.h2d_last)
            tail <= link.h2d_data;
        n_stored <= n_stored + int'(stored);
        n_drop <= n_drop + int'(dropped);
    end
    // cycle ceiling; the whole run needs a few hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand one cycle after the strobe, taken mid-cycle
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    task automatic wait_st(input int b);
        v = 32'h0;
        for (int i = 0; i < 40 && v[b] !== 1'b1; i++) rd_reg(8'h06);
        `CHK("status", 1'b1, v[b])
    endtask
    task automatic chk_resp(input logic [7:0] exp [$]);
        rd_reg(8'h09);
        `CHK("resp_len", exp.size(), v)
        foreach (exp[i])
        begin
            rd_reg(8'(8'h10 + i));
            `CHK("resp_byte", exp[i], v[7:0])
        end
    endtask
    task automatic hc_check(input logic p, input logic e, input logic k);
        rp <= p;
        en <= e;
        kv <= k;
        wr_reg(8'h08, 32'h7);
        wr_reg(8'h00, 32'h1);
        wait_st(0);
        chk_resp('{8'h81, 8'h00, 8'hA1, 8'hB2, p ? 8'hC3 : 8'h00, 8'hD4, {6'h00, e, k}});
    endtask
    // a rejected grant turns the null answer into a failure with one code per grant
    task automatic ba_check(input logic [4:0] r, input logic [7:0] exp [$]);
        rej <= r;
        wr_reg(8'h08, 32'h7);
        wr_reg(8'h00, 32'h2);
        wait_st((r == 5'h00) ? 1 : 2);
        chk_resp(exp);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wr_reg(8'h07, 32'h7);
        hc_check(1'b0, 1'b1, 1'b0);
        hc_check(1'b1, 1'b0, 1'b1);
        wr_reg(8'h01, 32'h5);
        wr_reg(8'h02, 32'h3C);
        wr_reg(8'h03, 32'h1);
        wr_reg(8'h04, 32'h3);
        wr_reg(8'h05, 32'h11223344);
        // middle satellite grant belongs to another terminal and must be dropped
        for (int k = 0; k < 3; k++)
            for (int j = 0; j < 9; j++) wr_reg(8'(64 + 9 * k + j), j ? 16 * k + j : 5 + 2 * (k == 1));
        ba_check(5'h00, '{8'h82});
        `CHK("frame", 8'h3C, frame)
        `CHK("count", 8'h02, count)
        `CHK("grant", 8'h21, gdat)
        `CHK("tod_tail", 8'h44, tail)
        `CHK("irq", 1'b1, irq)
        wr_reg(8'h08, 32'h7);
        repeat (2) @(posedge clk);
        `CHK("irq_clr", 1'b0, irq)
        ba_check(5'h02, '{8'h83, 8'h03, 8'h00, 8'h01});
        `CHK("stored", 1, n_stored)
        `CHK("dropped", 0, n_drop)
        wrap_up();
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
endmodule // tb_bandwidth_grant_message_handler
